/* bisq_pkg.sv */
// constants, register map and carrier types for the bus status query block
package bisq_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_SELECT = 8'h00;  // item select code, rw
  localparam logic [7:0] OFS_QUERY = 8'h04;  // value of selected item, ro
  localparam logic [7:0] OFS_QFLAGS = 8'h08;  // terminator flags of selected item, ro
  localparam logic [7:0] OFS_ADDR_ROLE = 8'h0c;  // address_role_status, ro
  localparam logic [7:0] OFS_EVT_ONE = 8'h10;  // bus_event_status_one, clear on read
  localparam logic [7:0] OFS_EVT_TWO = 8'h14;  // bus_event_status_two, clear on read
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;  // sticky interrupt status, ro
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;  // interrupt clear, wo
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;  // interrupt enable, rw
  localparam logic [7:0] OFS_IO_TMO = 8'h24;  // i/o timeout in ms, rw
  localparam logic [7:0] OFS_DMA_TMO = 8'h28;  // dma timeout in ms, rw
  localparam logic [7:0] OFS_OUT_TERM = 8'h30;  // four output terminators, 0x30..0x3c
  localparam logic [7:0] OFS_IN_TERM = 8'h40;  // four input terminators, 0x40..0x4c

  // select codes
  localparam logic [3:0] SEL_ADDR_ROLE = 4'h0;
  localparam logic [3:0] SEL_EVT_ONE = 4'h1;
  localparam logic [3:0] SEL_EVT_TWO = 4'h2;
  localparam logic [3:0] SEL_DMA_STAT = 4'h3;
  localparam logic [1:0] SEL_GRP_OUT = 2'h1;  // codes 4..7
  localparam logic [1:0] SEL_GRP_IN = 2'h2;  // codes 8..11
  localparam logic [3:0] SEL_IO_TMO = 4'hc;
  localparam logic [3:0] SEL_DMA_TMO = 4'hd;

  // field positions
  localparam int BIT_CONTROLLER = 7;
  localparam int BIT_LISTENER = 2;
  localparam int BIT_TALKER = 1;
  localparam int BIT_TRIGGER = 5;
  localparam int BIT_DEV_CLEAR = 3;
  localparam int BIT_SRQ_SEEN = 6;
  localparam int BIT_LOCKOUT = 5;
  localparam int BIT_REMOTE = 4;
  localparam int BIT_ROLE_CHG = 0;

  // interrupt status/enable/clear layout
  localparam int IRQ_W = 6;
  localparam int IRQ_ROLE_CHG = 0;
  localparam int IRQ_DEV_CLEAR = 1;
  localparam int IRQ_TRIGGER = 2;
  localparam int IRQ_SRQ = 3;
  localparam int IRQ_LOCKOUT = 4;
  localparam int IRQ_REMOTE = 5;

  // values after reset
  localparam logic [15:0] RST_IO_TMO = 16'h2710;
  localparam logic [15:0] RST_DMA_TMO = 16'h2710;
  localparam logic [17:0] RST_OUT_TERM = 18'h2000a;  // single lf with end flag
  localparam logic [7:0] RST_IN_TERM = 8'h0a;

  // addressing role of the board on the bus
  typedef struct packed {
    logic controller;
    logic listener;
    logic talker;
  } bisq_role_t;

  // one-cycle bus events and the service request level
  typedef struct packed {
    logic trigger;
    logic dev_clear;
    logic srq_line;
    logic lockout;
    logic remote;
  } bisq_bus_evt_t;

  // one output terminator entry
  typedef struct packed {
    logic eoi_last;
    logic terminator_two_byte;
    logic [15:0] chars;
  } bisq_out_term_t;

  // terminator transmit sequencer
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_HIGH = 2'b01,
    TS_LOW = 2'b10
  } bisq_tx_state_t;

endpackage : bisq_pkg

/* bisq_status_query.sv */
// bus interface status query block with axi4-lite register slave
// Function
// - four-bit select code picks the returned item
// - bit 7 shows controller in charge
// - bit 2 set while addressed as listener
// - bit 1 set while addressed as talker
// - trigger as non-controller sets event one bit 5
// - device clear sets event one bit 3
// - service request seen as controller sets bit 6
// - lockout in device mode sets bit 5
// - remote in device mode sets bit 4
// - any role change sets event two bit 0
// - reading event registers clears their set bits
// - terminator query returns the two-byte flag
// - terminator query returns the end-with-last-byte flag
// - upper byte of returned value reads zero except for output terminator and timeout items
// - input and single terminators in low byte
// - two-byte terminator sends upper byte first
// - timeouts are sixteen-bit millisecond counts
`timescale 1ns/1ps
module bisq_status_query
  import bisq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // bus side role and events
  input wire bisq_role_t role_in,
  input wire bisq_bus_evt_t bus_evt,
  // terminator transmit request from the transfer logic
  input wire logic term_send_req,
  input wire logic [1:0] term_send_sel,
  output logic term_busy,
  // terminator byte stream toward the bus
  output logic term_byte_valid,
  input wire logic term_byte_ready,
  output logic [7:0] term_byte,
  output logic term_byte_eoi,
  // timeout settings toward the transfer logic
  output logic [15:0] io_timeout_ms,
  output logic [15:0] dma_timeout_ms,
  // interrupt
  output logic irq
);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // write channel holding registers
  logic aw_held_q;  // write address taken, waiting for data
  logic [7:0] aw_addr_q;  // taken write address
  logic w_held_q;  // write data taken, waiting for address
  logic [31:0] w_data_q;  // taken write data
  logic [3:0] w_strb_q;  // taken byte strobes
  logic bvalid_q;  // write response pending
  logic [1:0] bresp_q;  // write response code
  // read channel registers
  logic rvalid_q;  // read data pending
  logic [31:0] rdata_q;  // read data
  logic [1:0] rresp_q;  // read response code
  // software visible state
  logic [3:0] sel_q;  // select code
  logic [7:0] evt_one_q;  // bus_event_status_one
  logic [7:0] evt_two_q;  // bus_event_status_two
  logic [IRQ_W-1:0] irq_stat_q;  // sticky interrupt status
  logic [IRQ_W-1:0] irq_en_q;  // interrupt enable
  logic [15:0] io_tmo_q;  // i/o timeout
  logic [15:0] dma_tmo_q;  // dma timeout
  bisq_out_term_t out_term_q [4];  // output terminators
  logic [7:0] in_term_q [4];  // input terminators
  // role tracking for change detection
  bisq_role_t role_prev_q;  // role seen on last edge
  logic role_seen_q;  // role_prev_q holds a real sample
  // terminator sequencer
  bisq_tx_state_t tx_state_q;
  bisq_tx_state_t tx_state_d;
  bisq_out_term_t tx_entry_q;  // entry being sent
  logic [7:0] tx_byte_q;  // byte on offer
  logic tx_eoi_q;  // end flag of byte on offer

  // handshakes; one transaction per direction at a time
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  // write decode on the held address
  wire [5:0] wa = aw_addr_q[7:2];
  wire wr_sel = wr_fire && (wa == OFS_SELECT[7:2]);
  wire wr_irq_clr = wr_fire && (wa == OFS_IRQ_CLR[7:2]);
  wire wr_irq_en = wr_fire && (wa == OFS_IRQ_EN[7:2]);
  wire wr_io = wr_fire && (wa == OFS_IO_TMO[7:2]);
  wire wr_dma = wr_fire && (wa == OFS_DMA_TMO[7:2]);
  wire wr_out = wr_fire && (wa[5:2] == OFS_OUT_TERM[7:4]);
  wire wr_in = wr_fire && (wa[5:2] == OFS_IN_TERM[7:4]);
  wire wr_hit = wr_sel || wr_irq_clr || wr_irq_en || wr_io || wr_dma || wr_out || wr_in;
  // byte lane mask from the strobes
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // read decode on the offered address
  wire [5:0] ra = s_axi_araddr[7:2];
  wire hit_sel = (ra == OFS_SELECT[7:2]);
  wire hit_query = (ra == OFS_QUERY[7:2]);
  wire hit_qflags = (ra == OFS_QFLAGS[7:2]);
  wire hit_role = (ra == OFS_ADDR_ROLE[7:2]);
  wire hit_evt_one = (ra == OFS_EVT_ONE[7:2]);
  wire hit_evt_two = (ra == OFS_EVT_TWO[7:2]);
  wire hit_irq_stat = (ra == OFS_IRQ_STAT[7:2]);
  wire hit_irq_clr = (ra == OFS_IRQ_CLR[7:2]);
  wire hit_irq_en = (ra == OFS_IRQ_EN[7:2]);
  wire hit_io = (ra == OFS_IO_TMO[7:2]);
  wire hit_dma = (ra == OFS_DMA_TMO[7:2]);
  wire hit_out = (ra[5:2] == OFS_OUT_TERM[7:4]);
  wire hit_in = (ra[5:2] == OFS_IN_TERM[7:4]);
  wire rd_hit = hit_sel || hit_query || hit_qflags || hit_role || hit_evt_one ||
                hit_evt_two || hit_irq_stat || hit_irq_clr || hit_irq_en || hit_io ||
                hit_dma || hit_out || hit_in;

  // address status byte; unused positions forced low
  wire [7:0] role_byte = {role_in.controller, 4'h0, role_in.listener,
                          role_in.talker, 1'b0};

  // selected item decode
  wire sel_role = (sel_q == SEL_ADDR_ROLE);
  wire sel_evt_one = (sel_q == SEL_EVT_ONE);
  wire sel_evt_two = (sel_q == SEL_EVT_TWO);
  wire sel_out = (sel_q[3:2] == SEL_GRP_OUT);
  wire sel_in = (sel_q[3:2] == SEL_GRP_IN);
  wire sel_io = (sel_q == SEL_IO_TMO);
  wire sel_dma = (sel_q == SEL_DMA_TMO);
  // dma status, port address and own bus address live elsewhere and read as zero here
  wire bisq_out_term_t sel_out_entry = out_term_q[sel_q[1:0]];
  // upper byte is zero except for output terminator and timeout items
  wire [15:0] query_val =
      ({16{sel_role}} & {8'h00, role_byte}) |
      ({16{sel_evt_one}} & {8'h00, evt_one_q}) |
      ({16{sel_evt_two}} & {8'h00, evt_two_q}) |
      ({16{sel_out}} & sel_out_entry.chars) |
      ({16{sel_in}} & {8'h00, in_term_q[sel_q[1:0]]}) |
      ({16{sel_io}} & io_tmo_q) |
      ({16{sel_dma}} & dma_tmo_q);
  // flags only meaningful for an output terminator
  wire [1:0] query_flags = sel_out ? {sel_out_entry.eoi_last, sel_out_entry.terminator_two_byte}
                                   : 2'b00;

  // read data multiplexer; clear register reads as zero
  wire [31:0] rd_mux =
      ({32{hit_sel}} & {28'h0, sel_q}) |
      ({32{hit_query}} & {16'h0, query_val}) |
      ({32{hit_qflags}} & {30'h0, query_flags}) |
      ({32{hit_role}} & {24'h0, role_byte}) |
      ({32{hit_evt_one}} & {24'h0, evt_one_q}) |
      ({32{hit_evt_two}} & {24'h0, evt_two_q}) |
      ({32{hit_irq_stat}} & {26'h0, irq_stat_q}) |
      ({32{hit_irq_en}} & {26'h0, irq_en_q}) |
      ({32{hit_io}} & {16'h0, io_tmo_q}) |
      ({32{hit_dma}} & {16'h0, dma_tmo_q}) |
      ({32{hit_out}} & {14'h0, out_term_q[ra[1:0]]}) |
      ({32{hit_in}} & {24'h0, in_term_q[ra[1:0]]});

  // read side effect: direct read or query read of an event register
  wire clr_evt_one = rd_fire && (hit_evt_one || (hit_query && sel_evt_one));
  wire clr_evt_two = rd_fire && (hit_evt_two || (hit_query && sel_evt_two));

  // event sources; trigger, lockout and remote gated to device mode, srq to controller mode, device clear and role change ungated
  wire role_chg = role_seen_q && (role_in != role_prev_q);
  wire ev_trigger = bus_evt.trigger && !role_in.controller;
  wire ev_dev_clear = bus_evt.dev_clear;
  wire ev_srq = bus_evt.srq_line && role_in.controller;
  wire ev_lockout = bus_evt.lockout && !role_in.controller;
  wire ev_remote = bus_evt.remote && !role_in.controller;
  wire [7:0] set_one = (8'(ev_trigger) << BIT_TRIGGER) | (8'(ev_dev_clear) << BIT_DEV_CLEAR);
  wire [7:0] set_two = (8'(ev_srq) << BIT_SRQ_SEEN) | (8'(ev_lockout) << BIT_LOCKOUT) |
                       (8'(ev_remote) << BIT_REMOTE) | (8'(role_chg) << BIT_ROLE_CHG);
  wire [IRQ_W-1:0] set_irq = {ev_remote, ev_lockout, ev_srq, ev_trigger, ev_dev_clear, role_chg};
  wire [IRQ_W-1:0] irq_clr_bits = wr_irq_clr ? w_data_q[IRQ_W-1:0] : '0;

  // write channel: take address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      // hold each half until the write fires
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (w_take)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  // write response; unmapped writes answer slverr and change nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // read response, data registered at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // control registers written by software; strobes honoured per byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= SEL_ADDR_ROLE;
      irq_en_q <= '0;
      io_tmo_q <= RST_IO_TMO;
      dma_tmo_q <= RST_DMA_TMO;
    end
    else
    begin
      if (wr_sel)
        sel_q <= (sel_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
      if (wr_irq_en)
        irq_en_q <= (irq_en_q & ~wmask[IRQ_W-1:0]) | (w_data_q[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
      if (wr_io)
        io_tmo_q <= (io_tmo_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
      if (wr_dma)
        dma_tmo_q <= (dma_tmo_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
    end
  end

  // terminator tables, one entry per generate step
  for (genvar i = 0; i < 4; i++)
  begin : g_term
    wire wr_out_i = wr_out && (wa[1:0] == 2'(i));
    wire wr_in_i = wr_in && (wa[1:0] == 2'(i));
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        out_term_q[i] <= RST_OUT_TERM;
        in_term_q[i] <= RST_IN_TERM;
      end
      else
      begin
        // single characters and input terminators sit in the low byte
        if (wr_out_i)
          out_term_q[i] <= (out_term_q[i] & ~wmask[17:0]) | (w_data_q[17:0] & wmask[17:0]);
        if (wr_in_i)
          in_term_q[i] <= (in_term_q[i] & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
      end
    end
  end

  // event registers: a new event in the clearing cycle survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_one_q <= 8'h00;
      evt_two_q <= 8'h00;
      irq_stat_q <= '0;
    end
    else
    begin
      evt_one_q <= (clr_evt_one ? 8'h00 : evt_one_q) | set_one;
      evt_two_q <= (clr_evt_two ? 8'h00 : evt_two_q) | set_two;
      irq_stat_q <= (irq_stat_q & ~irq_clr_bits) | set_irq;
    end
  end

  // previous role for change detection; first sample after reset is no change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      role_prev_q <= '0;
      role_seen_q <= 1'b0;
    end
    else
    begin
      role_prev_q <= role_in;
      role_seen_q <= 1'b1;
    end
  end

  // terminator sequencer next state
  always_comb
  begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TS_IDLE:
        if (term_send_req)
          tx_state_d = out_term_q[term_send_sel].terminator_two_byte ? TS_HIGH : TS_LOW;
      TS_HIGH:
        if (term_byte_ready)
          tx_state_d = TS_LOW;
      TS_LOW:
        if (term_byte_ready)
          tx_state_d = TS_IDLE;
      default:
        tx_state_d = TS_IDLE;
    endcase
  end

  // terminator sequencer registers; entry latched so rewrites cannot tear a send
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_q <= TS_IDLE;
      tx_entry_q <= '0;
      tx_byte_q <= 8'h00;
      tx_eoi_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      if (tx_state_q == TS_IDLE && term_send_req)
      begin
        // two-byte entries open with the upper byte
        tx_entry_q <= out_term_q[term_send_sel];
        tx_byte_q <= out_term_q[term_send_sel].terminator_two_byte ?
                     out_term_q[term_send_sel].chars[15:8] : out_term_q[term_send_sel].chars[7:0];
        tx_eoi_q <= !out_term_q[term_send_sel].terminator_two_byte &&
                    out_term_q[term_send_sel].eoi_last;
      end
      else if (tx_state_q == TS_HIGH && term_byte_ready)
      begin
        tx_byte_q <= tx_entry_q.chars[7:0];
        tx_eoi_q <= tx_entry_q.eoi_last;
      end
      else if (tx_state_q == TS_LOW && term_byte_ready)
        tx_eoi_q <= 1'b0;
    end
  end

  // outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign term_busy = (tx_state_q != TS_IDLE);
  assign term_byte_valid = (tx_state_q != TS_IDLE);
  assign term_byte = tx_byte_q;
  assign term_byte_eoi = tx_eoi_q;
  assign io_timeout_ms = io_tmo_q;
  assign dma_timeout_ms = dma_tmo_q;
  assign irq = |(irq_stat_q & irq_en_q);

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  role_byte_a: assert property (rd_fire && hit_role |=> rdata_q[7:0] ==
      {$past(role_in.controller), 4'h0, $past(role_in.listener), $past(role_in.talker), 1'b0})
    else $error("address role byte wrong");
  listen_bit_a: assert property (rd_fire && hit_query && sel_role |=>
      rdata_q[BIT_LISTENER] == $past(role_in.listener) && rdata_q[BIT_TALKER] == $past(role_in.talker))
    else $error("listener or talker bit wrong in query");
  talk_zero_a: assert property (rd_fire && hit_role && !role_in.talker |=> !rdata_q[1])
    else $error("talker bit set while not talker");
  trigger_set_a: assert property (bus_evt.trigger && !role_in.controller |=> evt_one_q[5])
    else $error("trigger event lost");
  trigger_gate_a: assert property (!evt_one_q[5] && !(bus_evt.trigger && !role_in.controller)
      |=> !evt_one_q[5])
    else $error("trigger bit set without cause");
  clear_set_a: assert property (bus_evt.dev_clear |=> evt_one_q[3])
    else $error("device clear event lost");
  srq_gate_a: assert property (!evt_two_q[6] && !role_in.controller |=> !evt_two_q[6])
    else $error("service request bit set outside controller mode");
  srq_set_a: assert property (bus_evt.srq_line && role_in.controller |=> evt_two_q[6])
    else $error("service request not recorded");
  device_evt_a: assert property (!role_in.controller && bus_evt.lockout && bus_evt.remote
      |=> evt_two_q[5] && evt_two_q[4])
    else $error("lockout or remote event lost");
  remote_gate_a: assert property (!evt_two_q[4] && role_in.controller |=> !evt_two_q[4])
    else $error("remote bit set in controller mode");
  role_change_a: assert property (role_seen_q && role_in != role_prev_q |=> evt_two_q[0])
    else $error("role change not recorded");
  read_clear_a: assert property (rd_fire && hit_evt_one && set_one == 8'h00
      |=> evt_one_q == 8'h00 && rdata_q[7:0] == $past(evt_one_q))
    else $error("event one not cleared by read");
  query_clear_a: assert property (rd_fire && hit_query && sel_evt_two && set_two == 8'h00
      |=> evt_two_q == 8'h00)
    else $error("event two not cleared by query read");
  term_flags_a: assert property (rd_fire && hit_qflags && sel_out |=> rdata_q[1:0] ==
      {$past(sel_out_entry.eoi_last), $past(sel_out_entry.terminator_two_byte)})
    else $error("terminator flags wrong");
  upper_zero_a: assert property (rd_fire && hit_query && sel_q <= SEL_DMA_STAT
      |=> rdata_q[31:8] == 24'h0)
    else $error("upper byte not zero");
  high_first_a: assert property (tx_state_q == TS_IDLE && term_send_req &&
      out_term_q[term_send_sel].terminator_two_byte
      |=> term_byte == tx_entry_q.chars[15:8] && !term_byte_eoi)
    else $error("two-byte terminator not upper first");
  last_eoi_a: assert property (tx_state_q == TS_HIGH && term_byte_ready |=>
      tx_state_q == TS_LOW && term_byte == tx_entry_q.chars[7:0] &&
      term_byte_eoi == tx_entry_q.eoi_last)
    else $error("low byte or end flag wrong");
  timeout_read_a: assert property (rd_fire && hit_query && sel_io |=>
      rdata_q == {16'h0, $past(io_tmo_q)})
    else $error("i/o timeout readback wrong");
  dont_care_a: assert property (rd_fire && hit_evt_two |=> rdata_q[3:1] == 3'h0)
    else $error("don't-care bits not zero");

  cov_read_clear: cover property (rd_fire && hit_evt_one && evt_one_q != 8'h00);
  cov_two_byte: cover property (tx_state_q == TS_HIGH ##[1:8] tx_state_q == TS_LOW);
  cov_irq: cover property (!irq ##1 irq);
  cov_set_on_clear: cover property (clr_evt_two && set_two != 8'h00);

endmodule : bisq_status_query

/* bisq_bus_model.sv */
// bus side model: role levels, event pulses and terminator byte acceptance
`timescale 1ns/1ps
module bisq_bus_model
  import bisq_pkg::*;
(
  // clock
  input wire logic aclk,
  // toward the block
  output bisq_role_t role_in,
  output bisq_bus_evt_t bus_evt,
  output logic term_byte_ready,
  // bench asks for a stalling acceptor
  input wire logic slow
);
  logic [1:0] cnt_q = 2'h0;  // stall phase counter
  initial
  begin
    role_in = '0;
    bus_evt = '0;
  end
  // role levels change just after an edge
  task set_role(input bisq_role_t r);
    role_in <= r;
  endtask : set_role
  // one-cycle bus event, srq held for that cycle only
  task pulse(input bisq_bus_evt_t e);
    bus_evt <= e;
    @(posedge aclk);
    bus_evt <= '0;
  endtask : pulse
  // slow mode takes one byte in four cycles to exercise holding
  always @(posedge aclk) cnt_q <= cnt_q + 2'h1;
  assign term_byte_ready = !slow || cnt_q == 2'h3;
endmodule : bisq_bus_model

/* testbench.sv */
// self-checking bench for the bus status query block
`timescale 1ns/1ps
module testbench;
  import bisq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, term_send_req, term_busy, term_byte_valid, term_byte_ready;
  logic term_byte_eoi, irq, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr, term_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, term_send_sel, rr_q;
  logic [3:0] s_axi_wstrb;
  logic [15:0] io_timeout_ms, dma_timeout_ms;
  bisq_role_t role_in;
  bisq_bus_evt_t bus_evt;
  int miscompares, n_tests, cyc;
  bisq_status_query uut (.*);
  bisq_bus_model bm (.*);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // hang guard, tests need well under this
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // write: address and data offered together, each dropped at its own take edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        ta = 1'b1;
      if (s_axi_wready)
        tw = 1'b1;
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end while (!(ta && tw));
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rr_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // read and compare data at the answer edge; response code kept in rr_q
  task rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rr_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
  endtask : rd
  task t_role;
    bm.set_role(3'b101);
    repeat (2) @(posedge aclk);
    rd(OFS_ADDR_ROLE, 32'h82);
    rd(OFS_EVT_TWO, 32'h01);
    rd(OFS_EVT_TWO, 32'h00);
    bm.set_role(3'b010);
    repeat (2) @(posedge aclk);
    rd(OFS_ADDR_ROLE, 32'h04);
    $display("role test done");
  endtask : t_role
  // event one is read while unaddressed and again as controller
  task t_evt;
    wr(OFS_IRQ_EN, 32'h3f);
    bm.set_role(3'b000);
    bm.pulse(5'b11000);
    rd(OFS_EVT_ONE, 32'h28);
    bm.pulse(5'b00011);
    rd(OFS_EVT_TWO, 32'h31);
    bm.set_role(3'b100);
    @(posedge aclk);
    bm.pulse(5'b10100);
    rd(OFS_EVT_ONE, 32'h00);
    rd(OFS_EVT_TWO, 32'h41);
    rd(OFS_IRQ_STAT, 32'h3f);
    chk(irq, 32'h1);
    wr(OFS_IRQ_CLR, 32'h3f);
    chk(irq, 32'h0);
    $display("event test done");
  endtask : t_evt
  task t_query;
    wr(OFS_OUT_TERM, 32'h2000a);
    wr(OFS_OUT_TERM + 8'h04, 32'h30d0a);
    wr(OFS_SELECT, 32'h5);
    rd(OFS_QUERY, 32'h0d0a);
    rd(OFS_QFLAGS, 32'h3);
    wr(OFS_SELECT, 32'h4);
    rd(OFS_QUERY, 32'h0a);
    rd(OFS_QFLAGS, 32'h2);
    wr(OFS_SELECT, 32'h8);
    rd(OFS_QUERY, {24'h0, RST_IN_TERM});
    wr(OFS_IO_TMO, 32'hffff);
    chk(rr_q, 32'h0);
    wr(OFS_SELECT, 32'hc);
    rd(OFS_QUERY, 32'hffff);
    chk(io_timeout_ms, 32'hffff);
    rd(8'h2c, 32'h0);
    chk(rr_q, 32'h2);
    wr(8'h2c, 32'h1);
    chk(rr_q, 32'h2);
    chk(dma_timeout_ms, {16'h0, RST_DMA_TMO});
    s_axi_wstrb <= 4'h1;
    wr(OFS_DMA_TMO, 32'h1234);
    s_axi_wstrb <= 4'hf;
    chk(dma_timeout_ms, {16'h0, RST_DMA_TMO[15:8], 8'h34});
    $display("query test done");
  endtask : t_query
  // two-byte then single-byte terminator against a stalling acceptor
  task t_term;
    int n;
    slow <= 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      n = 0;
      @(posedge aclk);
      term_send_sel <= 2'(s);
      term_send_req <= 1'b1;
      @(posedge aclk);
      term_send_req <= 1'b0;
      while (n <= s)
      begin
        @(negedge aclk);
        if (term_byte_valid && term_byte_ready)
        begin
          chk({term_busy, term_byte_eoi, term_byte}, n == s ? 32'h30a : 32'h20d);
          n++;
        end
      end
      @(negedge aclk);
      chk({term_busy, term_byte_valid}, 32'h0);
    end
    $display("terminator test done");
  endtask : t_term
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, term_send_req, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, term_send_sel} = '0;
    {miscompares, n_tests, cyc} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_role();
    t_evt();
    t_query();
    t_term();
    give_verdict();
  end
endmodule : testbench
